// ==== logic/acr_defines.svh ====
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets on the serial port
// ----------------------------------------------------------------
`define ACR_OFS_IFSEL 7'h07
`define ACR_OFS_TSCLK 7'h0f
`define ACR_OFS_TCONV 7'h10
`define ACR_OFS_DLLAZ 7'h11
`define ACR_OFS_FUSE 7'h13
`define ACR_OFS_PAT0 7'h14
`define ACR_OFS_PAT1 7'h15
`define ACR_OFS_PAT2 7'h16
`define ACR_OFS_SCKA 7'h18
`define ACR_OFS_FRAME_CLOCK 7'h19
`define ACR_OFS_MAP 7'h1b
`define ACR_OFS_SKEW 7'h1e
`define ACR_OFS_OBUF 7'h1f
`define ACR_OFS_FPAT0 7'h20
`define ACR_OFS_FPAT1 7'h21
`define ACR_OFS_FPAT2 7'h22
`define ACR_OFS_DIG 7'h24

// ----------------------------------------------------------------
// writable bit masks, reserved bits stay zero
// ----------------------------------------------------------------
`define ACR_MSK_IFSEL 8'hef
`define ACR_MSK_TSCLK 8'h07
`define ACR_MSK_TCONV 8'h04
`define ACR_MSK_DLLAZ 8'h25
`define ACR_MSK_FUSE 8'h01
`define ACR_MSK_FULL 8'hff
`define ACR_MSK_PAT2 8'h1f
`define ACR_MSK_SCKA 8'h10
`define ACR_MSK_FRAME_CLOCK 8'h92
`define ACR_MSK_MAP 8'hf8
`define ACR_MSK_SKEW 8'h30
`define ACR_MSK_OBUF 8'hd8
`define ACR_MSK_FPAT2 8'hcf
`define ACR_MSK_DIG 8'h06
`define ACR_MSK_NONE 8'h00

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ACR_RST_ZERO 8'h00
`define ACR_RST_OBUF 8'h10
`define ACR_RST_FPAT0 8'h00
`define ACR_RST_FPAT1 8'hfc
`define ACR_RST_FPAT2 8'h0f
`define ACR_RST_DLLAZ_SLOW 8'h01
`define ACR_RST_DLLAZ_FAST 8'h00
`define ACR_RST_FPAT 20'hffc00

// ----------------------------------------------------------------
// bit positions and fields
// ----------------------------------------------------------------
`define ACR_B_TCONV 2
`define ACR_B_DLL 2
`define ACR_B_AZ 0
`define ACR_B_FUSE 0
`define ACR_B_IFEN 3
`define ACR_B_SCKA 4
`define ACR_B_SCKB 6
`define ACR_B_FSRC 7
`define ACR_B_FDIV 4
`define ACR_B_FEN 1
`define ACR_B_MAPEN 7
`define ACR_B_WIDE 6
`define ACR_B_DRV 4
`define ACR_B_X2 3
`define ACR_B_DIG 2
`define ACR_B_DDC 1
`define ACR_F_TSCLK 2:0
`define ACR_F_IFSEL 2:0
`define ACR_F_TPAT 4:2
`define ACR_F_PATHI 1:0
`define ACR_F_MRES 5:3
`define ACR_F_SKEW 5:4
`define ACR_F_FPATHI 3:0
`define ACR_F_SCR 7:6

// ----------------------------------------------------------------
// codes
// ----------------------------------------------------------------
`define ACR_TP_RAMP 3'h2
`define ACR_TP_CONST 3'h3
`define ACR_RES_16 3'h1
`define ACR_RES_14 3'h2
`define ACR_SCR_NONE 2'h0
`define ACR_MASK18 18'h3ffff
`define ACR_MASK16 18'h3fffc
`define ACR_MASK14 18'h3fff0
`define ACR_NATIVE_PAD 4'h0
`define ACR_WIDE_PAD 2'h0
`define ACR_RAMP_ZERO 18'h00000
`define ACR_FPAT_LAST 5'd19
`define ACR_FPOS_ZERO 5'd0
`define ACR_FPOS_ONE 5'd1
`define ACR_FRAME_CLOCK_PIN_IDX 0

// ----------------------------------------------------------------
// serial frame
// ----------------------------------------------------------------
`define ACR_SPI_LAST 4'd7
`define ACR_SPI_DONE 4'd8
`define ACR_SPI_ZERO 4'd0
`define ACR_SPI_ONE 4'd1
`define ACR_SPI_RD_BIT 6

`endif

// ==== logic/acr_pkg.sv ====
package acr_pkg;

  // serial port states
  typedef enum logic [2:0] {
    ACR_SPI_IDLE,
    ACR_SPI_HDR,
    ACR_SPI_RDAT,
    ACR_SPI_WDAT,
    ACR_SPI_WAIT
  } acr_spi_st_t;

  // effective configuration driven to the converter core
  typedef struct packed {
    logic [2:0] sensor_clock_sel;
    logic sensor_conversion_start;
    logic sample_delay_loop_off;
    logic half_period_sampling;
    logic autozero_enable;
    logic [2:0] output_interface_sel;
    logic serial_clock_in_enable;
    logic frame_clock_source;
    logic frame_clock_divide;
    logic frame_clock_output_enable;
    logic mapper_enable;
    logic wide_output_enable;
    logic [2:0] mapper_resolution;
    logic [1:0] data_clock_skew;
    logic data_clock_driver_enable;
    logic double_clock_mode;
    logic [19:0] frame_clock_pattern;
    logic [1:0] output_scramble_sel;
    logic digital_path_enable;
    logic decimator_enable;
  } acr_cfg_t;

endpackage

// ==== logic/acr_spi_slave.sv ====
`timescale 1ns/100ps
`include "acr_defines.svh"

module acr_spi_slave import acr_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial pins
  input wire logic spi_sen_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // register side
  output logic wr_valid,
  output logic [6:0] wr_addr,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic sen_s1, sen_s2, sclk_s1, sclk_s2, sclk_s3, sdi_s1, sdi_s2;
  acr_spi_st_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  wire logic sclk_rise;
  wire logic sclk_fall;
  wire logic [7:0] byte_in;

  // edges come from the second and third stages
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {sen_s1, sen_s2} <= 2'h3;
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
      {sdi_s1, sdi_s2} <= 2'h0;
    end else begin
      {sen_s1, sen_s2} <= {spi_sen_n, sen_s1};
      {sclk_s1, sclk_s2, sclk_s3} <= {spi_sclk, sclk_s1, sclk_s2};
      {sdi_s1, sdi_s2} <= {spi_sdi, sdi_s1};
    end
  end

  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign sclk_fall = ~sclk_s2 & sclk_s3;
  assign byte_in = {sh_q[6:0], sdi_s2};

  // ----------------------------------------------------------------
  // frame engine: 8 header bits, then 8 data bits, msb first
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= ACR_SPI_IDLE;
      cnt_q <= `ACR_SPI_ZERO;
      sh_q <= 8'h00;
      wr_valid <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
      spi_sdo <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else begin
      wr_valid <= 1'b0;
      if (sen_s2) begin
        // deselect aborts any frame, a partial write is dropped
        st_q <= ACR_SPI_IDLE;
        spi_sdo_oe <= 1'b0;
      end else begin
        case (st_q)
          ACR_SPI_IDLE: begin
            st_q <= ACR_SPI_HDR;
            cnt_q <= `ACR_SPI_ZERO;
          end
          ACR_SPI_HDR: begin
            if (sclk_rise) begin
              sh_q <= byte_in;
              cnt_q <= cnt_q + `ACR_SPI_ONE;
              if (cnt_q == `ACR_SPI_LAST) begin
                wr_addr <= byte_in[6:0];
                cnt_q <= `ACR_SPI_ZERO;
                st_q <= sh_q[`ACR_SPI_RD_BIT] ? ACR_SPI_RDAT : ACR_SPI_WDAT;
              end
            end
          end
          ACR_SPI_RDAT: begin
            // data leaves on falling edges, host samples on rising
            if (sclk_fall) begin
              spi_sdo_oe <= 1'b1;
              if (cnt_q == `ACR_SPI_ZERO) begin
                spi_sdo <= rd_data[7];
                sh_q <= {rd_data[6:0], 1'b0};
              end else begin
                spi_sdo <= sh_q[7];
                sh_q <= {sh_q[6:0], 1'b0};
              end
            end
            if (sclk_rise) begin
              cnt_q <= cnt_q + `ACR_SPI_ONE;
              if (cnt_q == `ACR_SPI_LAST) begin
                st_q <= ACR_SPI_WAIT;
              end
            end
          end
          ACR_SPI_WDAT: begin
            if (sclk_rise) begin
              sh_q <= byte_in;
              cnt_q <= cnt_q + `ACR_SPI_ONE;
              if (cnt_q == `ACR_SPI_LAST) begin
                wr_data <= byte_in;
                wr_valid <= 1'b1;
                st_q <= ACR_SPI_WAIT;
              end
            end
          end
          ACR_SPI_WAIT: begin
            st_q <= ACR_SPI_WAIT;
          end
          default: begin
            st_q <= ACR_SPI_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_wr_single: assert property (@(posedge clk) disable iff (!nrst)
    wr_valid |=> !wr_valid)
    else $error("write strobe longer than one cycle");

endmodule

// ==== logic/acr_config_regs.sv ====
`timescale 1ns/100ps
`include "acr_defines.svh"


module acr_config_regs import acr_pkg::*; #(
  parameter bit FAST_VARIANT = 1'b0,
  parameter logic [2:0] DEFAULT_IF = 3'h0
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial programming port
  input wire logic spi_sen_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // converter samples
  input wire logic [13:0] adc_sample,
  input wire logic adc_valid,
  // configuration to the core
  output acr_cfg_t cfg_q,
  // output data path
  output logic [19:0] out_word_q,
  output logic out_valid_q,
  output logic frame_clock_q,
  output logic data_pin_q
);

  // ----------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_mask(input logic [6:0] a);
    case (a)
      `ACR_OFS_IFSEL: reg_mask = `ACR_MSK_IFSEL;
      `ACR_OFS_TSCLK: reg_mask = `ACR_MSK_TSCLK;
      `ACR_OFS_TCONV: reg_mask = `ACR_MSK_TCONV;
      `ACR_OFS_DLLAZ: reg_mask = `ACR_MSK_DLLAZ;
      `ACR_OFS_FUSE: reg_mask = `ACR_MSK_FUSE;
      `ACR_OFS_PAT0: reg_mask = `ACR_MSK_FULL;
      `ACR_OFS_PAT1: reg_mask = `ACR_MSK_FULL;
      `ACR_OFS_PAT2: reg_mask = `ACR_MSK_PAT2;
      `ACR_OFS_SCKA: reg_mask = `ACR_MSK_SCKA;
      `ACR_OFS_FRAME_CLOCK: reg_mask = `ACR_MSK_FRAME_CLOCK;
      `ACR_OFS_MAP: reg_mask = `ACR_MSK_MAP;
      `ACR_OFS_SKEW: reg_mask = `ACR_MSK_SKEW;
      `ACR_OFS_OBUF: reg_mask = `ACR_MSK_OBUF;
      `ACR_OFS_FPAT0: reg_mask = `ACR_MSK_FULL;
      `ACR_OFS_FPAT1: reg_mask = `ACR_MSK_FULL;
      `ACR_OFS_FPAT2: reg_mask = `ACR_MSK_FPAT2;
      `ACR_OFS_DIG: reg_mask = `ACR_MSK_DIG;
      default: reg_mask = `ACR_MSK_NONE;
    endcase
  endfunction

  function automatic logic [7:0] reg_reset(input logic [6:0] a);
    case (a)
      // autozero default depends on the variant
      `ACR_OFS_DLLAZ: reg_reset = FAST_VARIANT ? `ACR_RST_DLLAZ_FAST
                                               : `ACR_RST_DLLAZ_SLOW;
      // data clock driver is on out of reset
      `ACR_OFS_OBUF: reg_reset = `ACR_RST_OBUF;
      `ACR_OFS_FPAT0: reg_reset = `ACR_RST_FPAT0;
      `ACR_OFS_FPAT1: reg_reset = `ACR_RST_FPAT1;
      `ACR_OFS_FPAT2: reg_reset = `ACR_RST_FPAT2;
      default: reg_reset = `ACR_RST_ZERO;
    endcase
  endfunction

  // the fuse path and its own trigger survive a fuse load
  function automatic logic keeps_on_fuse(input logic [6:0] a);
    keeps_on_fuse = (a == `ACR_OFS_IFSEL) || (a == `ACR_OFS_FUSE);
  endfunction

  // ----------------------------------------------------------------
  // serial port
  // ----------------------------------------------------------------
  logic wr_valid;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  wire logic [7:0] rd_data;
  logic [7:0] regs_q [128];

  acr_spi_slave u_spi (
    .clk(clk),
    .nrst(nrst),
    .spi_sen_n(spi_sen_n),
    .spi_sclk(spi_sclk),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .wr_valid(wr_valid),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  // unmapped offsets hold zero, so a plain index answers them
  assign rd_data = regs_q[wr_addr];

  // ----------------------------------------------------------------
  // fuse load sequencing
  // ----------------------------------------------------------------
  logic fuse_prev_q;
  logic fuse_clear_q;
  logic [2:0] if_sel_q;
  wire logic fuse_bit;
  wire logic fuse_fall;

  assign fuse_bit = regs_q[`ACR_OFS_FUSE][`ACR_B_FUSE];
  // the load fires on the high-to-low step of the bit
  assign fuse_fall = fuse_prev_q & ~fuse_bit;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fuse_prev_q <= 1'b0;
      fuse_clear_q <= 1'b0;
      if_sel_q <= DEFAULT_IF;
    end else begin
      fuse_prev_q <= fuse_bit;
      fuse_clear_q <= fuse_fall;
      // a new interface only counts with change enable
      if (fuse_fall) begin
        if (regs_q[`ACR_OFS_IFSEL][`ACR_B_IFEN]) begin
          if_sel_q <= regs_q[`ACR_OFS_IFSEL][`ACR_F_IFSEL];
        end else begin
          if_sel_q <= DEFAULT_IF;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register array
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 128; gi++) begin : g_reg
      wire logic hit;
      assign hit = wr_valid && (wr_addr == 7'(gi));
      // a fuse load clears, but a write landing with it wins
      always_ff @(posedge clk) begin
        if (!nrst) begin
          regs_q[gi] <= reg_reset(7'(gi));
        end else if (hit) begin
          regs_q[gi] <= wr_data & reg_mask(7'(gi));
        end else if (fuse_clear_q && !keeps_on_fuse(7'(gi))) begin
          regs_q[gi] <= reg_reset(7'(gi));
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  acr_cfg_t cfg_d;
  wire logic dig_on;

  assign dig_on = regs_q[`ACR_OFS_DIG][`ACR_B_DIG];

  // sensor clock band code passes straight through
  assign cfg_d.sensor_clock_sel = regs_q[`ACR_OFS_TSCLK][`ACR_F_TSCLK];
  // measurement runs while the bit is set
  assign cfg_d.sensor_conversion_start =
    regs_q[`ACR_OFS_TCONV][`ACR_B_TCONV];
  // delay loop only exists on the fast variant
  assign cfg_d.sample_delay_loop_off =
    FAST_VARIANT & regs_q[`ACR_OFS_DLLAZ][`ACR_B_DLL];
  assign cfg_d.half_period_sampling =
    FAST_VARIANT & regs_q[`ACR_OFS_DLLAZ][`ACR_B_DLL];
  assign cfg_d.autozero_enable = regs_q[`ACR_OFS_DLLAZ][`ACR_B_AZ];
  assign cfg_d.output_interface_sel = if_sel_q;
  assign cfg_d.serial_clock_in_enable =
    regs_q[`ACR_OFS_SCKA][`ACR_B_SCKA] & regs_q[`ACR_OFS_OBUF][`ACR_B_SCKB];
  // 0 from converter, 1 from decimator
  assign cfg_d.frame_clock_source = regs_q[`ACR_OFS_FRAME_CLOCK][`ACR_B_FSRC];
  // divide bit is forwarded as programmed
  assign cfg_d.frame_clock_divide = regs_q[`ACR_OFS_FRAME_CLOCK][`ACR_B_FDIV];
  assign cfg_d.frame_clock_output_enable =
    regs_q[`ACR_OFS_FRAME_CLOCK][`ACR_B_FEN];
  assign cfg_d.mapper_enable = regs_q[`ACR_OFS_MAP][`ACR_B_MAPEN];
  assign cfg_d.wide_output_enable = regs_q[`ACR_OFS_MAP][`ACR_B_WIDE];
  assign cfg_d.mapper_resolution = regs_q[`ACR_OFS_MAP][`ACR_F_MRES];
  // skew code goes to the output clock delay line
  assign cfg_d.data_clock_skew = regs_q[`ACR_OFS_SKEW][`ACR_F_SKEW];
  assign cfg_d.data_clock_driver_enable =
    regs_q[`ACR_OFS_OBUF][`ACR_B_DRV];
  // serializer uses both clock edges when set
  assign cfg_d.double_clock_mode = regs_q[`ACR_OFS_OBUF][`ACR_B_X2];
  assign cfg_d.frame_clock_pattern = {
    regs_q[`ACR_OFS_FPAT2][`ACR_F_FPATHI],
    regs_q[`ACR_OFS_FPAT1],
    regs_q[`ACR_OFS_FPAT0]};
  // scrambling only exists inside the feature path
  assign cfg_d.output_scramble_sel = dig_on ?
    regs_q[`ACR_OFS_FPAT2][`ACR_F_SCR] : `ACR_SCR_NONE;
  assign cfg_d.digital_path_enable = dig_on;
  // decimator needs the feature path too
  assign cfg_d.decimator_enable = dig_on & regs_q[`ACR_OFS_DIG][`ACR_B_DDC];

  // registered so every core control comes from a flop
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------------------------------
  // test pattern and bit mapper
  // ----------------------------------------------------------------
  logic [17:0] ramp_q;
  logic [4:0] fpos_q;
  wire logic [17:0] pat_word;
  wire logic [17:0] sample_word;
  wire logic [17:0] src_word;
  wire logic [17:0] map_mask;
  wire logic [17:0] mapped;
  wire logic [19:0] out_d;
  wire logic [2:0] tp_sel;
  wire logic mapper_on;
  wire logic frame_bit;

  assign pat_word = {regs_q[`ACR_OFS_PAT2][`ACR_F_PATHI],
                     regs_q[`ACR_OFS_PAT1], regs_q[`ACR_OFS_PAT0]};
  assign tp_sel = regs_q[`ACR_OFS_PAT2][`ACR_F_TPAT];
  // native 14-bit sample sits at the msb end
  assign sample_word = {adc_sample, `ACR_NATIVE_PAD};
  // unused codes fall back to normal data
  assign src_word = (tp_sel == `ACR_TP_CONST) ? pat_word :
                    (tp_sel == `ACR_TP_RAMP) ? ramp_q : sample_word;
  // mapper changes width only while the decimator is off
  assign mapper_on = cfg_q.mapper_enable & ~cfg_q.decimator_enable;
  assign map_mask = !mapper_on ? `ACR_MASK14 :
    (cfg_q.mapper_resolution == `ACR_RES_16) ? `ACR_MASK16 :
    (cfg_q.mapper_resolution == `ACR_RES_14) ? `ACR_MASK14 : `ACR_MASK18;
  assign mapped = src_word & map_mask;
  // wide mode left-justifies into 20 bits
  assign out_d = cfg_q.wide_output_enable ? {mapped, `ACR_WIDE_PAD}
                                          : {`ACR_WIDE_PAD, mapped};
  assign frame_bit = cfg_q.frame_clock_pattern[fpos_q];

  // ramp restarts from zero whenever it is not selected
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ramp_q <= `ACR_RAMP_ZERO;
    end else if (tp_sel != `ACR_TP_RAMP) begin
      ramp_q <= `ACR_RAMP_ZERO;
    end else if (adc_valid) begin
      // step size is the pattern word
      ramp_q <= ramp_q + pat_word;
    end
  end

  // frame pattern walks one bit per sample
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fpos_q <= `ACR_FPOS_ZERO;
    end else if (adc_valid) begin
      fpos_q <= (fpos_q == `ACR_FPAT_LAST) ? `ACR_FPOS_ZERO
                                           : fpos_q + `ACR_FPOS_ONE;
    end
  end

  // output flops
  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_word_q <= '0;
      out_valid_q <= 1'b0;
      frame_clock_q <= 1'b0;
      data_pin_q <= 1'b0;
    end else begin
      out_valid_q <= adc_valid;
      if (adc_valid) begin
        out_word_q <= out_d;
        frame_clock_q <= frame_bit;
        // shared pin carries frame clock or a data bit
        data_pin_q <= cfg_q.frame_clock_output_enable ?
                      frame_bit : out_d[`ACR_FRAME_CLOCK_PIN_IDX];
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_fuse_discard: assert property (@(posedge clk) disable iff (!nrst)
    fuse_clear_q && !wr_valid |=> regs_q[`ACR_OFS_DIG] == `ACR_RST_ZERO)
    else $error("fuse load kept an earlier write");

  a_if_change_gate: assert property (@(posedge clk) disable iff (!nrst)
    fuse_fall && !regs_q[`ACR_OFS_IFSEL][`ACR_B_IFEN] |=>
    if_sel_q == DEFAULT_IF)
    else $error("interface changed without change enable");

  a_sclk_in_both: assert property (@(posedge clk) disable iff (!nrst)
    !regs_q[`ACR_OFS_SCKA][`ACR_B_SCKA] [*2] |->
    !cfg_q.serial_clock_in_enable)
    else $error("serial clock input on with one enable");

  // checked one cycle on, so the very first edge never sees unset flops
  a_drv_reset: assert property (@(posedge clk)
    !nrst |=> regs_q[`ACR_OFS_OBUF] == `ACR_RST_OBUF)
    else $error("driver enable not set after reset");

  a_fpat_reset: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nrst) |=> cfg_q.frame_clock_pattern == `ACR_RST_FPAT)
    else $error("frame pattern reset value wrong");

  a_ramp_step: assert property (@(posedge clk) disable iff (!nrst)
    tp_sel == `ACR_TP_RAMP && adc_valid && $stable(tp_sel)
    ##1 tp_sel == `ACR_TP_RAMP |-> ramp_q == $past(ramp_q) + $past(pat_word))
    else $error("ramp did not step by pattern word");

  a_const_word: assert property (@(posedge clk) disable iff (!nrst)
    adc_valid && tp_sel == `ACR_TP_CONST && !mapper_on &&
    !cfg_q.wide_output_enable |=>
    out_word_q == {`ACR_WIDE_PAD, $past(pat_word) & `ACR_MASK14})
    else $error("constant pattern not on output");

  a_dig_bypass: assert property (@(posedge clk) disable iff (!nrst)
    !dig_on |=> cfg_q.output_scramble_sel == `ACR_SCR_NONE &&
    !cfg_q.decimator_enable)
    else $error("feature path active while bypassed");

  a_frame_pin: assert property (@(posedge clk) disable iff (!nrst)
    adc_valid && cfg_q.frame_clock_output_enable |=>
    data_pin_q == frame_clock_q)
    else $error("frame clock missing from shared pin");

endmodule

// ==== test/acr_testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import acr_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk = 1'h0, nrst = 1'h0, adc_valid = 1'h0;
  logic spi_sen_n = 1'h1, spi_sclk = 1'h0, spi_sdi = 1'h0;
  logic [13:0] adc_sample = 14'h0000;
  logic spi_sdo, spi_sdo_oe, out_valid_q, frame_clock_q, data_pin_q;
  logic [19:0] out_word_q;
  acr_cfg_t cfg_q;
  int n_fail = 0, cmp_count = 0;
  logic [31:0] seed = 32'h00006cdf;
  logic [7:0] rd;
  logic [17:0] pat, acc;
  logic [19:0] fp;
  int nv = 0;
  logic [6:0] ad [12] = '{7'h0f, 7'h10, 7'h14, 7'h15, 7'h16, 7'h18,
    7'h19, 7'h1b, 7'h1e, 7'h1f, 7'h22, 7'h24};
  logic [7:0] mk [12] = '{8'h07, 8'h04, 8'hff, 8'hff, 8'h1f, 8'h10,
    8'h92, 8'hf8, 8'h30, 8'hd8, 8'hcf, 8'h06};
  logic [7:0] mp [5] = '{8'h80, 8'h88, 8'h90, 8'h00, 8'h40};

  acr_config_regs dut_u (.clk, .nrst, .spi_sen_n, .spi_sclk, .spi_sdi,
    .spi_sdo, .spi_sdo_oe, .adc_sample, .adc_valid, .cfg_q, .out_word_q,
    .out_valid_q, .frame_clock_q, .data_pin_q);

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  function automatic void nx();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endfunction

  // mapped word: resolution mask only when the mapper is on, wide shifts up
  function automatic logic [19:0] ew(input logic [17:0] p,
    input logic [7:0] m);
    logic [17:0] w;
    w = p & (!m[7] ? 18'h3fff0 : m[5:3] == 3'h0 ? 18'h3ffff :
      m[5:3] == 3'h1 ? 18'h3fffc : 18'h3fff0);
    return m[6] ? {w, 2'h0} : {2'h0, w};
  endfunction

  task chk(input logic [19:0] g, input logic [19:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  // ----------------------------------------------------------------
  // serial frame: each sclk level held 5 clk, sync needs about 3
  // ----------------------------------------------------------------
  task spi(input logic rw, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {rw, a, d};
    @(posedge clk) spi_sen_n <= 1'h0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi <= f[i];
      repeat (5) @(posedge clk);
      if (i < 8) rd[i] = spi_sdo;
      if (i == 0 && rw) chk({19'h0, spi_sdo_oe}, 20'h1);
      spi_sclk <= 1'h1;
      repeat (5) @(posedge clk);
      spi_sclk <= 1'h0;
    end
    repeat (5) @(posedge clk);
    spi_sen_n <= 1'h1;
    repeat (8) @(posedge clk);
  endtask

  task rdchk(input logic [6:0] a, input logic [7:0] e);
    spi(1'h1, a, 8'h00);
    chk({12'h000, rd}, {12'h000, e});
    chk({19'h0, spi_sdo_oe}, 20'h0);
  endtask

  task smp();
    nx();
    @(posedge clk) begin
      adc_sample <= seed[13:0];
      adc_valid <= 1'h1;
    end
    @(posedge clk) adc_valid <= 1'h0;
    #1;
    chk({19'h0, out_valid_q}, 20'h1);
    chk({19'h0, frame_clock_q}, {19'h0, fp[nv % 20]});
    chk({19'h0, data_pin_q}, {19'h0, fp[nv % 20]});
    nv++;
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog: the whole sequence needs about 10000 cycles
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    close_out;
  end

  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    chk(cfg_q.frame_clock_pattern, 20'hffc00);
    chk({19'h0, cfg_q.data_clock_driver_enable}, 20'h1);
    rdchk(7'h1f, 8'h10);
    rdchk(7'h21, 8'hfc);
    rdchk(7'h11, 8'h01);
    $display("end reset values");
    for (int k = 0; k < 12; k++) begin
      nx();
      spi(1'h0, ad[k], seed[7:0]);
      rdchk(ad[k], seed[7:0] & mk[k]);
    end
    rdchk(7'h30, 8'h00);
    $display("end register access");
    // fuse load must undo the random writes above
    spi(1'h0, 7'h07, 8'h0b);
    spi(1'h0, 7'h13, 8'h01);
    spi(1'h0, 7'h13, 8'h00);
    chk({17'h0, cfg_q.output_interface_sel}, 20'h3);
    rdchk(7'h1f, 8'h10);
    spi(1'h0, 7'h18, 8'h10);
    chk({19'h0, cfg_q.serial_clock_in_enable}, 20'h0);
    spi(1'h0, 7'h1f, 8'h50);
    chk({19'h0, cfg_q.serial_clock_in_enable}, 20'h1);
    $display("end fuse load");
    // random low frame pattern byte, shared pin shows the frame clock
    nx();
    fp = {12'hffc, seed[7:0]};
    spi(1'h0, 7'h20, seed[7:0]);
    spi(1'h0, 7'h19, 8'h12);
    chk({19'h0, cfg_q.frame_clock_divide}, 20'h1);
    nx();
    pat = seed[17:0];
    spi(1'h0, 7'h14, pat[7:0]);
    spi(1'h0, 7'h15, pat[15:8]);
    spi(1'h0, 7'h16, {6'h03, pat[17:16]});
    for (int k = 0; k < 5; k++) begin
      spi(1'h0, 7'h1b, mp[k]);
      smp();
      chk(out_word_q, ew(pat, mp[k]));
    end
    spi(1'h0, 7'h16, 8'h00);
    smp();
    chk(out_word_q, ew({adc_sample, 4'h0}, 8'h40));
    // ramp starts at zero and steps by the pattern word per sample
    spi(1'h0, 7'h16, {6'h02, pat[17:16]});
    acc = 18'h00000;
    for (int k = 0; k < 3; k++) begin
      smp();
      chk(out_word_q, ew(acc, 8'h40));
      acc = acc + pat;
    end
    $display("end data path");
    spi(1'h0, 7'h22, 8'hcf);
    spi(1'h0, 7'h24, 8'h02);
    chk({18'h0, cfg_q.output_scramble_sel}, 20'h0);
    chk({19'h0, cfg_q.decimator_enable}, 20'h0);
    spi(1'h0, 7'h24, 8'h06);
    chk({18'h0, cfg_q.output_scramble_sel}, 20'h3);
    chk({19'h0, cfg_q.decimator_enable}, 20'h1);
    // second load without change enable falls back to the default
    spi(1'h0, 7'h07, 8'h03);
    spi(1'h0, 7'h13, 8'h01);
    spi(1'h0, 7'h13, 8'h00);
    chk({17'h0, cfg_q.output_interface_sel}, 20'h0);
    rdchk(7'h24, 8'h00);
    $display("end feature path");
    close_out;
  end
endmodule
